// ---- verilog/uprc_top.v ----
// Port routing, port power, power event, clock enables and power-on reset filter.
// Operation
// R01: High-speed ownership blocks full-speed port writes.
// R02: High-speed-only port bits hidden from full-speed.
// R03: Two ownership bits steer routing multiplexer.
// R04: Reset gives every port to full-speed.
// R05: Host driver alone changes ownership bits.
// R06: Full-speed serves 12 or 1.5 Mbit/s.
// R07: High-speed serves owned port at 480.
// R08: Low overcurrent input per port flags fault.
// R09: Low power enable per port applies power.
// R10: Underscore-N USB pins are active low.
// R11: Open-drain low power event requests change.
// R12: Derive 30 and 48 MHz enables internally.
// R13: Hold reset at least 200 ns after rise.
// R14: Ignore supply dips of 11 us or less.
// R15: Reassert reset after dips over 11 us.
// R16: Mux transceiver and status to selected owner.
`timescale 1ns/100ps
`default_nettype none
`include "uprc_defs.vh"
module uprc_top #(
   parameter DIP_CYC = `UPRC_DIP_CYC
) (
   input wire sys_clk,
   input wire reset_n,
   input wire supply_ok_hi,
   input wire supply_ok_lo,
   input wire [1:0] hs_own_wr,
   input wire [1:0] hs_own_val,
   input wire [1:0] fs_port_wr,
   input wire [15:0] fs_port_wdata,
   input wire [15:0] hs_port_wdata,
   input wire [1:0] hs_port_wr,
   input wire [1:0] fs_low_speed,
   input wire [1:0] port_power_req,
   input wire pme_req,
   input wire [1:0] xcvr_status,
   input wire port1_overcurrent_n,
   input wire port2_overcurrent_n,
   output wire [1:0] port_owner,
   output wire [15:0] fs_port_rdata,
   output wire [15:0] hs_port_rdata,
   output wire [1:0] fs_port_status,
   output wire [1:0] hs_port_status,
   output wire [1:0] fs_speed_sel,
   output wire [1:0] hs_speed_480,
   output wire [1:0] port_overcurrent,
   output reg port1_power_on_n,
   output reg port2_power_on_n,
   output wire pme_n_out,
   output wire pme_n_oe,
   output reg clk30_en,
   output reg clk48_en,
   output wire internal_power_on_reset_pulse
);
   localparam [`UPRC_CNT_W-1:0] INTERNAL_POWER_ON_RESET_PULSE_CNT = `UPRC_INTERNAL_POWER_ON_RESET_PULSE_CYC;
   localparam [`UPRC_CNT_W-1:0] DIP_CNT = DIP_CYC;
   reg [1:0] own_ff;
   reg [7:0] port_reg_ff [0:1];
   reg pme_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [`UPRC_CNT_W-1:0] cnt_ff;
   reg [`UPRC_CNT_W-1:0] nxt_cnt;
   reg [3:0] div30_ff;
   reg [4:0] div48_ff;
   wire oc1_s;
   wire oc2_s;
   wire hi_s;
   wire lo_s;
   wire por_n;
   // Returns high when an ownership bit selects the high-speed controller.
   function uprc_is_hs;
      input owner_bit;
      begin
         uprc_is_hs = (owner_bit == `UPRC_OWN_HS);
      end
   endfunction
   // Overcurrent pins and supply detectors come from outside this clock domain.
   uprc_sync3 u_oc1 (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(port1_overcurrent_n),
      .rst_val(1'b1), .sync_out(oc1_s));
   uprc_sync3 u_oc2 (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(port2_overcurrent_n),
      .rst_val(1'b1), .sync_out(oc2_s));
   uprc_sync3 u_hi (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(supply_ok_hi),
      .rst_val(1'b1), .sync_out(hi_s));
   uprc_sync3 u_lo (.sys_clk(sys_clk), .reset_n(reset_n), .async_in(supply_ok_lo),
      .rst_val(1'b1), .sync_out(lo_s));
   assign port_overcurrent = {~oc2_s, ~oc1_s}; // [R08] [R10]
   // Power-on reset filter sequencer.
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         `UPRC_ST_RESET: begin
            nxt_cnt = {`UPRC_CNT_W{1'b0}};
            if (hi_s) begin
               nxt_state = `UPRC_ST_HOLD;
            end
         end
         `UPRC_ST_HOLD: begin
            if (!hi_s) begin
               nxt_state = `UPRC_ST_RESET;
            end else if (cnt_ff >= INTERNAL_POWER_ON_RESET_PULSE_CNT - 1'b1) begin
               nxt_state = `UPRC_ST_RUN; // [R13]
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         `UPRC_ST_RUN: begin
            nxt_cnt = {`UPRC_CNT_W{1'b0}};
            if (!lo_s) begin
               nxt_state = `UPRC_ST_DIP;
            end
         end
         // A dip longer than the filter span brings the internal reset back.
         `UPRC_ST_DIP: begin
            if (lo_s) begin
               nxt_state = `UPRC_ST_RUN; // [R14]
            end else if (cnt_ff >= DIP_CNT - 1'b1) begin
               nxt_state = `UPRC_ST_RESET; // [R15]
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         default: begin
            nxt_state = `UPRC_ST_RESET;
         end
      endcase
   end
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= `UPRC_ST_RESET;
         cnt_ff <= {`UPRC_CNT_W{1'b0}};
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end
   assign internal_power_on_reset_pulse = (state_ff == `UPRC_ST_RESET) ||
      (state_ff == `UPRC_ST_HOLD); // [R13] [R15]
   assign por_n = ~internal_power_on_reset_pulse;
   // Clock enable dividers for 30 and 48 MHz domains.
   // Each accumulator adds a step and wraps, so pulses come 3 in 10 and 12 in 25 cycles.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div30_ff <= 4'h0;
         div48_ff <= 5'h00;
         clk30_en <= 1'b0;
         clk48_en <= 1'b0;
      end else begin
         clk30_en <= 1'b0;
         clk48_en <= 1'b0;
         if (div30_ff >= `UPRC_DIV_30) begin
            div30_ff <= div30_ff - `UPRC_DIV_30;
            clk30_en <= 1'b1; // [R12]
         end else begin
            div30_ff <= div30_ff + `UPRC_STEP_30;
         end
         if (div48_ff >= `UPRC_DIV_48) begin
            div48_ff <= div48_ff - `UPRC_DIV_48;
            clk48_en <= 1'b1; // [R12]
         end else begin
            div48_ff <= div48_ff + `UPRC_STEP_48;
         end
      end
   end
   // Ownership, port registers, power enables and power event.
   genvar p;
   generate
      for (p = 0; p < `UPRC_NPORTS; p = p + 1) begin : g_port
         // Writes are qualified by the current owner of the port.
         // A full-speed write leaves the high-speed-only upper bits untouched.
         wire hs_wr_ok;
         wire fs_wr_ok;
         assign hs_wr_ok = hs_port_wr[p] & uprc_is_hs(own_ff[p]);
         assign fs_wr_ok = fs_port_wr[p] & ~uprc_is_hs(own_ff[p]); // [R01]
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               own_ff[p] <= `UPRC_OWN_FS; // [R04]
               port_reg_ff[p] <= 8'h00;
            end else if (!por_n) begin
               own_ff[p] <= `UPRC_OWN_FS; // [R04]
               port_reg_ff[p] <= 8'h00;
            end else begin
               if (hs_own_wr[p]) begin
                  own_ff[p] <= hs_own_val[p]; // [R03] [R05]
               end
               if (hs_wr_ok) begin
                  port_reg_ff[p] <= hs_port_wdata[p*8 +: 8];
               end else if (fs_wr_ok) begin
                  port_reg_ff[p] <= (port_reg_ff[p] & `UPRC_HS_ONLY_MASK) |
                     (fs_port_wdata[p*8 +: 8] & `UPRC_FS_MASK); // [R01] [R02]
               end
            end
         end
         assign fs_port_rdata[p*8 +: 8] = port_reg_ff[p] & `UPRC_FS_MASK; // [R02]
         assign hs_port_rdata[p*8 +: 8] = port_reg_ff[p];
         assign fs_port_status[p] = ~uprc_is_hs(own_ff[p]) & xcvr_status[p]; // [R16]
         assign hs_port_status[p] = uprc_is_hs(own_ff[p]) & xcvr_status[p]; // [R16]
         assign fs_speed_sel[p] = fs_low_speed[p] ? `UPRC_SPD_LOW : `UPRC_SPD_FULL; // [R06]
         assign hs_speed_480[p] = uprc_is_hs(own_ff[p]); // [R07]
      end
   endgenerate
   assign port_owner = own_ff;
   // Port power and the power event are withdrawn while the internal reset is high.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port1_power_on_n <= 1'b1;
         port2_power_on_n <= 1'b1;
         pme_ff <= 1'b0;
      end else begin
         port1_power_on_n <= ~(port_power_req[0] & por_n); // [R09] [R10]
         port2_power_on_n <= ~(port_power_req[1] & por_n); // [R09] [R10]
         pme_ff <= pme_req & por_n;
      end
   end
   assign pme_n_out = 1'b0; // [R11]
   assign pme_n_oe = pme_ff; // [R11]
endmodule // uprc_top
`default_nettype wire

// ---- verilog/uprc_defs.vh ----
// Constants for the USB port routing controller.
`ifndef UPRC_DEFS_VH
`define UPRC_DEFS_VH
`define UPRC_CLK_MHZ 100
`define UPRC_INTERNAL_POWER_ON_RESET_PULSE_MIN_NS 200
`define UPRC_INTERNAL_POWER_ON_RESET_PULSE_CYC ((`UPRC_INTERNAL_POWER_ON_RESET_PULSE_MIN_NS * `UPRC_CLK_MHZ + 999) / 1000)
`define UPRC_DIP_US 11
`define UPRC_DIP_CYC (`UPRC_DIP_US * `UPRC_CLK_MHZ)
`define UPRC_CNT_W 12
`define UPRC_NPORTS 2
`define UPRC_OWN_FS 1'b0
`define UPRC_OWN_HS 1'b1
`define UPRC_SPD_FULL 1'b0
`define UPRC_SPD_LOW 1'b1
`define UPRC_HS_ONLY_MASK 8'hF0
`define UPRC_FS_MASK 8'h0F
`define UPRC_ST_RESET 2'b00
`define UPRC_ST_HOLD 2'b01
`define UPRC_ST_RUN 2'b10
`define UPRC_ST_DIP 2'b11
`define UPRC_DIV_30 4'h7
`define UPRC_STEP_30 4'h3
`define UPRC_DIV_48 5'h0D
`define UPRC_STEP_48 5'h0C
`endif

// ---- verilog/uprc_sync3.v ----
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module uprc_sync3 (
   input wire sys_clk,
   input wire reset_n,
   input wire async_in,
   input wire rst_val,
   output reg sync_out
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            sync_out <= s3_ff;
         end
      end
   end
   wire unused_rst_val = rst_val;
endmodule // uprc_sync3
`default_nettype wire

// ---- verification/uprc_usb_dev_model.sv ----
// Behavioural USB devices on the two downstream ports.
`timescale 1ns/100ps
`default_nettype none
module uprc_usb_dev_model (
   input wire logic sys_clk,
   input wire logic [1:0] fault,
   input wire logic port1_power_on_n,
   input wire logic port2_power_on_n,
   output var logic port1_overcurrent_n = 1'b1,
   output var logic port2_overcurrent_n = 1'b1,
   output var logic [1:0] xcvr_status = 2'b00
);
   always @(negedge sys_clk) begin
      port1_overcurrent_n <= !(fault[0] && !port1_power_on_n);
      port2_overcurrent_n <= !(fault[1] && !port2_power_on_n);
      xcvr_status <= {!port2_power_on_n, !port1_power_on_n};
   end
endmodule // uprc_usb_dev_model
`default_nettype wire

// ---- verification/uprc_top_assertions.sv ----
// Assertion checker for the port routing controller.
`timescale 1ns/100ps
`default_nettype none
module uprc_top_assertions #(parameter DIP_CYC = 20) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic supply_ok_lo,
   input wire logic [1:0] hs_own_wr,
   input wire logic [1:0] hs_own_val,
   input wire logic [1:0] hs_port_wr,
   input wire logic [1:0] xcvr_status,
   input wire logic port1_overcurrent_n,
   input wire logic [1:0] port_owner,
   input wire logic [15:0] fs_port_rdata,
   input wire logic [15:0] hs_port_rdata,
   input wire logic [1:0] fs_port_status,
   input wire logic [1:0] hs_port_status,
   input wire logic [1:0] port_overcurrent,
   input wire logic internal_power_on_reset_pulse
);
   logic [11:0] lo_run_ff;
   wire por = internal_power_on_reset_pulse;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence oc_held; !port1_overcurrent_n [*8]; endsequence
   always @(posedge sys_clk or negedge reset_n)
      if (!reset_n) lo_run_ff <= 12'h000;
      else lo_run_ff <= supply_ok_lo ? 12'h000 : lo_run_ff + 12'h001;
   a_owner_cause: assert property (
      $changed(port_owner) |-> por || $past(por) || $past(|hs_own_wr)) else $error("owner");
   a_owner_take: assert property (
      hs_own_wr[0] && !por |=> port_owner[0] == $past(hs_own_val[0])) else $error("take");
   a_owner_por: assert property (por |=> port_owner == 2'b00) else $error("por");
   a_fs_hidden: assert property ((fs_port_rdata & 16'hF0F0) == 16'h0000)
      else $error("hidden");
   a_fs_block: assert property (
      port_owner[0] && !hs_port_wr[0] |=> $stable(hs_port_rdata[7:0]) || por) else $error("blk");
   a_status_mux: assert property (
      {fs_port_status, hs_port_status} == {xcvr_status & ~port_owner, xcvr_status & port_owner})
      else $error("mux");
   a_oc_sense: assert property (oc_held |-> port_overcurrent[0]) else $error("oc");
   a_long_dip: assert property (lo_run_ff == DIP_CYC + 8 |-> por) else $error("dip");
endmodule // uprc_top_assertions
bind uprc_top uprc_top_assertions #(.DIP_CYC(DIP_CYC)) uprc_top_assertions_i (.*);
`default_nettype wire

// ---- verification/tb_usb_port_routing_ctrl.sv ----
// Self-checking bench for the port routing controller.
`timescale 1ns/100ps
`default_nettype none
module tb_usb_port_routing_ctrl;
   localparam DIP = 20;
   logic sys_clk = 1'b0, reset_n = 1'b0, supply_ok_hi = 1'b1, supply_ok_lo = 1'b1, pme_req;
   logic [1:0] hs_own_wr, hs_own_val, fs_port_wr, hs_port_wr, fs_low_speed, port_power_req;
   logic [1:0] fault, xcvr_status, port_owner, fs_port_status, hs_port_status, fs_speed_sel;
   logic [1:0] hs_speed_480, port_overcurrent, eo;
   logic [15:0] fs_port_wdata, hs_port_wdata, fs_port_rdata, hs_port_rdata, er, n30, n48;
   logic port1_overcurrent_n, port2_overcurrent_n, port1_power_on_n, port2_power_on_n;
   logic pme_n_out, pme_n_oe, clk30_en, clk48_en, internal_power_on_reset_pulse;
   logic [31:0] v;
   int error_cnt = 0, check_count = 0, seed = 32'h5629_181b, i;
   uprc_top #(.DIP_CYC(DIP)) uprc_top_i (.*);
   uprc_usb_dev_model uprc_usb_dev_model_i (.*);
   initial forever #5 sys_clk = ~sys_clk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      n30 += clk30_en;
      n48 += clk48_en;
      if (internal_power_on_reset_pulse) begin
         eo <= 2'b00;
         er <= 16'h0000;
      end else for (int p = 0; p < 2; p++) begin
         if (hs_own_wr[p]) eo[p] <= hs_own_val[p];
         if (hs_port_wr[p] && eo[p]) er[p*8+:8] <= hs_port_wdata[p*8+:8];
         if (fs_port_wr[p] && !eo[p]) er[p*8+:4] <= fs_port_wdata[p*8+:4];
      end
   end
   initial begin
      {pme_req, hs_own_wr, hs_own_val, fs_port_wr, hs_port_wr, fs_low_speed} = '0;
      {port_power_req, fault, fs_port_wdata, hs_port_wdata, eo, er} = '0;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk) reset_n = 1'b1;
      for (i = 0; i < 100 && internal_power_on_reset_pulse; i++) @(negedge sys_clk);
      repeat (400) begin
         chk(port_owner, eo);
         chk(hs_speed_480, eo);
         chk(hs_port_rdata, er);
         chk(fs_port_rdata, er & 16'h0F0F);
         chk(fs_speed_sel, fs_low_speed);
         chk({fs_port_status, hs_port_status}, {xcvr_status & ~eo, xcvr_status & eo});
         v = $random(seed);
         {pme_req, fault, port_power_req, fs_low_speed, hs_port_wr, fs_port_wr, hs_own_val} = v[12:0];
         hs_own_wr = v[15:14] & v[17:16];
         fs_port_wdata = $random(seed);
         hs_port_wdata = $random(seed);
         @(negedge sys_clk);
      end
      {port_power_req, fault, hs_own_wr, hs_own_val, fs_port_wr, hs_port_wr} = 12'hFF0;
      pme_req = 1'b1;
      repeat (12) @(negedge sys_clk);
      chk(port_overcurrent, 2'b11);
      chk({port2_power_on_n, port1_power_on_n}, 2'b00);
      chk({pme_n_oe, pme_n_out}, 2'b10);
      {n30, n48, hs_own_wr} = '0;
      repeat (100) @(negedge sys_clk);
      chk(n30, 30);
      chk(n48, 48);
      supply_ok_lo = 1'b0;
      repeat (DIP) @(negedge sys_clk);
      supply_ok_lo = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk({internal_power_on_reset_pulse, port_owner}, 3'b011);
      {supply_ok_hi, supply_ok_lo} = 2'b00;
      repeat (DIP + 12) @(negedge sys_clk);
      chk({internal_power_on_reset_pulse, port_owner}, 3'b100);
      {supply_ok_hi, supply_ok_lo} = 2'b11;
      for (i = 0; i < 60 && internal_power_on_reset_pulse; i++) @(negedge sys_clk);
      chk(i >= 20 && i < 60, 1);
      final_report;
   end
   initial begin
      #20000;
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      final_report;
   end
endmodule // tb_usb_port_routing_ctrl
`default_nettype wire
